// *** bench/rtcs_host.sv ***
`timescale 1ns/1ps
module rtcs_host (
    // Clock
    clk,
    // Serial data interface pins
    cs,
    sclk,
    sdata
);
    input wire logic clk;
    output logic cs;
    output logic sclk;
    output logic sdata;
    // ==========================================
    // Host calibration sequence
    // Clock rests low outside frames; data line changes only with command bits and reference cycles
    localparam int HALF = 4;
    initial begin
        cs = 1'b0;
        sclk = 1'b0;
        sdata = 1'b0;
    end
    task automatic wait_cyc(input int n, input logic tog);
        repeat (n) begin
            @(posedge clk);
            if (tog) sdata <= ~sdata;
        end
    endtask
    task automatic run(input logic [7:0] code, input int n_ref);
        @(posedge clk);
        cs <= 1'b1;
        wait_cyc(8, 1'b0);
        for (int i = 7; i >= 0; i--) begin
            sdata <= code[i];
            sclk <= 1'b1;
            wait_cyc(HALF, 1'b0);
            sclk <= 1'b0;
            wait_cyc(HALF, 1'b0);
        end
        // Reference cycles at 8 clocks each, data toggling throughout
        for (int k = 0; k < n_ref; k++) begin
            sclk <= 1'b1;
            wait_cyc(HALF, 1'b1);
            sclk <= 1'b0;
            wait_cyc(HALF, 1'b1);
        end
        cs <= 1'b0;
        wait_cyc(8, 1'b0);
    endtask
endmodule

// *** bench/rtcs_trim_test.sv ***
`timescale 1ns/1ps
`define chk(nm, exp, got) \
    begin \
        check_count++; \
        if ((got) !== (exp)) begin \
            err_total++; \
            $display("mismatch %s expected %h seen %h", nm, exp, got); \
        end \
    end
module rtcs_trim_test;
    // ==========================================
    // Signals and instances
    typedef logic [6:0] rtcs_row_t;
    localparam int REF_CYC = 8;
    localparam int EXP_TRIM = (rtcs_pkg::CAL_EDGES - 1) * REF_CYC;
    // Rows: sel, pd, xtal_in, rc_osc -> rc_osc_en, src, rtc
    localparam rtcs_row_t ROWS [4] = '{7'h0d, 7'h28, 7'h53, 7'h4a};
    logic clk, nrst, sel, pd, cs, sclk, sdata, xtal_in, rc_osc, busy_seen;
    logic rtc_clk_q, rtc_src_xtal_q, rc_osc_en_q, trim_valid_q, cal_busy_q;
    logic [15:0] rc_trim_q;
    int busy_cnt = 0;
    int err_total = 0;
    int check_count = 0;
    rtcs_trim i_rtcs_trim (.clk(clk), .nrst(nrst), .clock_source_select(sel),
        .power_down(pd), .cs(cs), .sclk(sclk), .sdata(sdata), .crystal_input_pin(xtal_in),
        .rc_osc_clk(rc_osc), .rtc_clk_q(rtc_clk_q), .rtc_src_xtal_q(rtc_src_xtal_q),
        .rc_osc_en_q(rc_osc_en_q), .rc_trim_q(rc_trim_q), .trim_valid_q(trim_valid_q),
        .cal_busy_q(cal_busy_q));
    rtcs_host i_rtcs_host (.clk(clk), .cs(cs), .sclk(sclk), .sdata(sdata));
    initial clk = 1'b0;
    always #50 clk = ~clk;
    // Busy cycles are counted, so each calibration can tell whether it was entered
    always @(posedge clk) if (cal_busy_q === 1'b1) busy_cnt <= busy_cnt + 1;
    task automatic conclude();
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic cal(input logic [7:0] code, input int n);
        int busy0;
        busy0 = busy_cnt;
        i_rtcs_host.run(code, n);
        @(negedge clk);
        busy_seen = (busy_cnt != busy0);
    endtask
    // ==========================================
    // Sequence
    initial begin
        nrst = 1'b0;
        sel = 1'b0;
        pd = 1'b0;
        xtal_in = 1'b1;
        rc_osc = 1'b0;
        busy_seen = 1'b0;
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        settle(1);
        `chk("valid_after_reset", 1'b0, trim_valid_q)
        foreach (ROWS[i]) begin
            @(posedge clk);
            {sel, pd, xtal_in, rc_osc} <= ROWS[i][6:3];
            settle(5);
            `chk("rc_osc_en", ROWS[i][2], rc_osc_en_q)
            `chk("src_xtal", ROWS[i][1], rtc_src_xtal_q)
            `chk("rtc_clk", ROWS[i][0], rtc_clk_q)
        end
        @(posedge clk);
        {sel, pd, rc_osc} <= 3'h1;
        cal(8'h3a, 65);
        `chk("busy_wrong_code", 1'b0, busy_seen)
        `chk("valid_wrong_code", 1'b0, trim_valid_q)
        cal(rtcs_pkg::TRIM_CMD, 64);
        `chk("busy_short", 1'b1, busy_seen)
        `chk("valid_short", 1'b0, trim_valid_q)
        cal(rtcs_pkg::TRIM_CMD, 65);
        `chk("valid_full", 1'b1, trim_valid_q)
        `chk("trim_range", 1'b1, rc_trim_q >= EXP_TRIM - 1 && rc_trim_q <= EXP_TRIM + 1)
        `chk("busy_done", 1'b0, cal_busy_q)
        settle(20);
        `chk("valid_held", 1'b1, trim_valid_q)
        @(posedge clk);
        pd <= 1'b1;
        settle(3);
        `chk("rc_osc_en_pd", 1'b0, rc_osc_en_q)
        `chk("valid_pd", 1'b0, trim_valid_q)
        `chk("trim_pd", 16'h0000, rc_trim_q)
        @(posedge clk);
        pd <= 1'b0;
        settle(3);
        `chk("valid_lost", 1'b0, trim_valid_q)
        @(posedge clk);
        sel <= 1'b1;
        cal(rtcs_pkg::TRIM_CMD, 65);
        `chk("busy_xtal", 1'b0, busy_seen)
        `chk("valid_xtal", 1'b0, trim_valid_q)
        @(posedge clk);
        sel <= 1'b0;
        cal(rtcs_pkg::TRIM_CMD, 65);
        `chk("valid_again", 1'b1, trim_valid_q)
        @(posedge clk);
        nrst <= 1'b0;
        settle(1);
        `chk("valid_por", 1'b0, trim_valid_q)
        `chk("rc_osc_en_por", 1'b0, rc_osc_en_q)
        @(posedge clk);
        nrst <= 1'b1;
        settle(2);
        `chk("valid_after_por", 1'b0, trim_valid_q)
        `chk("rc_osc_en_release", 1'b1, rc_osc_en_q)
        conclude();
    end
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        $display("mismatch run_time expected end seen timeout");
        conclude();
    end
endmodule

// *** hw/rtcs_pkg.sv ***
// ==========================================================================
// Constants for RTC source selection and RC oscillator trim
package rtcs_pkg;
    // Synchroniser depth for every pin that crosses into clk
    localparam int SYNC_STAGES = 2;
    // Serial command word length and the trim direct command code
    localparam int CMD_W = 8;
    // Command code value is arbitrary, no code is given for it
    localparam logic [7:0] TRIM_CMD = 8'hc5;
    // Reference clock cycles that make up one calibration
    localparam int CAL_EDGES = 65;
    localparam int EDGE_W = 7;
    localparam logic [6:0] CAL_EDGES_M1 = 7'h40;
    localparam logic [3:0] CMD_BITS_M1 = 4'h7;
    // Default width of the measured trim value
    localparam int TRIM_W_DEF = 16;
    // Reset values
    localparam logic [15:0] TRIM_RST = 16'h0000;
    localparam logic [3:0] BITS_RST = 4'h0;
    localparam logic [6:0] EDGES_RST = 7'h00;
endpackage

// *** hw/rtcs_trim.sv ***
`timescale 1ns/1ps
// Behaviour
// R1: Source select 1 picks crystal, 0 picks RC
// R2: External clock host uses crystal setting, output pin floating
// R3: Calibration starts only on trim direct command
// R4: RC off in power down, reset, crystal
// R5: Trim volatile, lost when RC goes off
// R6: Host raises chip select before trim command
// R7: Host sends exactly 65 reference clock cycles
// R8: Host lowers chip select after reference cycles
// R9: Trim applied at 65th edge, kept until off
// R10: Host holds external clock high in power down
// R11: RTC frequency near quarter of carrier
// R12: During calibration serial clock is only reference
module rtcs_trim #(
    parameter int TRIM_W = rtcs_pkg::TRIM_W_DEF
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Configuration from the device's own logic
    input wire logic clock_source_select,
    input wire logic power_down,
    // Serial data interface pins
    input wire logic cs,
    input wire logic sclk,
    input wire logic sdata,
    // Oscillator inputs
    input wire logic crystal_input_pin,
    input wire logic rc_osc_clk,
    // RTC clock and oscillator control
    output logic rtc_clk_q,
    output logic rtc_src_xtal_q,
    output logic rc_osc_en_q,
    // Calibration result
    output logic [TRIM_W-1:0] rc_trim_q,
    output logic trim_valid_q,
    output logic cal_busy_q
);

    // ======================================================================
    // Parameter check
    if (TRIM_W < 10 || TRIM_W > 16) begin : g_trim_w_check
        $error("rtcs_trim: TRIM_W must be 10 to 16");
    end

    // ======================================================================
    // Pin synchronisers
    // Every pin passes two flops; the extra flop per strobe gives edges
    logic [4:0] pin_a;
    logic [4:0] pin_s;
    logic cs_p_q;
    logic sclk_p_q;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pin_a <= 5'h00;
            pin_s <= 5'h00;
            cs_p_q <= 1'b0;
            sclk_p_q <= 1'b0;
        end else begin
            pin_a <= {rc_osc_clk, crystal_input_pin, sdata, sclk, cs};
            pin_s <= pin_a;
            cs_p_q <= pin_s[0];
            sclk_p_q <= pin_s[1];
        end
    end

    logic cs_s;
    logic sclk_s;
    logic sdata_s;
    logic xtal_in_s;
    logic rc_osc_s;
    logic cs_rise;
    logic cs_fall;
    logic sclk_rise;
    logic sclk_fall;

    assign cs_s = pin_s[0];
    assign sclk_s = pin_s[1];
    assign sdata_s = pin_s[2];
    assign xtal_in_s = pin_s[3];
    assign rc_osc_s = pin_s[4];
    assign cs_rise = cs_s & ~cs_p_q;
    assign cs_fall = ~cs_s & cs_p_q;
    assign sclk_rise = sclk_s & ~sclk_p_q;
    assign sclk_fall = ~sclk_s & sclk_p_q;

    // ======================================================================
    // Clock source and RC oscillator enable
    logic rc_osc_on;
    logic rtc_clk_d;

    // RC runs only when neither power down nor crystal is chosen
    assign rc_osc_on = ~power_down & ~clock_source_select; // see R4

    always_comb begin
        // Crystal and external clock share the crystal input path
        rtc_clk_d = clock_source_select ? xtal_in_s : (rc_osc_s & rc_osc_on); // see R1
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rtc_clk_q <= 1'b0;
            rtc_src_xtal_q <= 1'b0;
            rc_osc_en_q <= 1'b0; // see R4
        end else begin
            rtc_clk_q <= rtc_clk_d;
            rtc_src_xtal_q <= clock_source_select; // see R1
            rc_osc_en_q <= rc_osc_on;
        end
    end

    // ======================================================================
    // Command decode and calibration sequencer
    typedef enum logic [1:0] {
        RTCS_IDLE,
        RTCS_CMD,
        RTCS_CAL,
        RTCS_WAIT
    } rtcs_state_t;

    rtcs_state_t state_q, state_d;
    logic [rtcs_pkg::CMD_W-1:0] cmd_q, cmd_d;
    logic [3:0] bits_q, bits_d;
    logic [rtcs_pkg::EDGE_W-1:0] edges_q, edges_d;
    logic [TRIM_W-1:0] cyc_q, cyc_d;
    logic [TRIM_W-1:0] trim_d;
    logic trim_valid_d;
    logic apply;
    logic [rtcs_pkg::CMD_W-1:0] cmd_word;

    assign cmd_word = {cmd_q[rtcs_pkg::CMD_W-2:0], sdata_s};

    always_comb begin
        state_d = state_q;
        cmd_d = cmd_q;
        bits_d = bits_q;
        edges_d = edges_q;
        cyc_d = cyc_q;
        apply = 1'b0;
        case (state_q)
            RTCS_IDLE: begin
                if (cs_rise) begin
                    state_d = RTCS_CMD;
                    bits_d = rtcs_pkg::BITS_RST;
                end
            end
            RTCS_CMD: begin
                if (cs_fall) begin
                    state_d = RTCS_IDLE;
                end else if (sclk_fall) begin
                    cmd_d = cmd_word;
                    bits_d = bits_q + 4'h1;
                    if (bits_q == rtcs_pkg::CMD_BITS_M1) begin
                        // Other commands belong to the rest of the interface
                        if (cmd_word == rtcs_pkg::TRIM_CMD && rc_osc_on) begin
                            state_d = RTCS_CAL; // see R3
                            edges_d = rtcs_pkg::EDGES_RST;
                        end else begin
                            state_d = RTCS_WAIT;
                        end
                    end
                end
            end
            RTCS_CAL: begin
                // Serial data is not looked at here, only clock and chip select edges and the RC oscillator enable
                if (cs_fall || !rc_osc_on) begin
                    state_d = RTCS_IDLE; // see R12
                end else begin
                    if (edges_q != rtcs_pkg::EDGES_RST && cyc_q != {TRIM_W{1'b1}}) begin
                        cyc_d = cyc_q + 1'b1;
                    end
                    if (sclk_rise) begin
                        edges_d = edges_q + 7'h01; // see R12
                        if (edges_q == rtcs_pkg::EDGES_RST) begin
                            cyc_d = '0;
                        end
                        if (edges_q == rtcs_pkg::CAL_EDGES_M1) begin
                            apply = 1'b1; // see R9
                            state_d = RTCS_WAIT;
                        end
                    end
                end
            end
            RTCS_WAIT: begin
                if (cs_fall) begin
                    state_d = RTCS_IDLE;
                end
            end
            default: begin
                state_d = RTCS_IDLE;
            end
        endcase
    end

    always_comb begin
        // Volatile: losing the oscillator drops the calibration
        if (!rc_osc_on) begin
            trim_d = rtcs_pkg::TRIM_RST[TRIM_W-1:0]; // see R5
            trim_valid_d = 1'b0;
        end else if (apply) begin
            // Cycles of clk spanning 64 reference periods
            trim_d = cyc_d; // see R9
            trim_valid_d = 1'b1;
        end else begin
            trim_d = rc_trim_q;
            trim_valid_d = trim_valid_q;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= RTCS_IDLE;
            cmd_q <= '0;
            bits_q <= rtcs_pkg::BITS_RST;
            edges_q <= rtcs_pkg::EDGES_RST;
            cyc_q <= '0;
            rc_trim_q <= rtcs_pkg::TRIM_RST[TRIM_W-1:0];
            trim_valid_q <= 1'b0;
            cal_busy_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cmd_q <= cmd_d;
            bits_q <= bits_d;
            edges_q <= edges_d;
            cyc_q <= cyc_d;
            rc_trim_q <= trim_d;
            trim_valid_q <= trim_valid_d;
            cal_busy_q <= (state_d == RTCS_CAL);
        end
    end

    // ======================================================================
    // Assertions
    sequence s_last_ref_edge;
        state_q == RTCS_CAL && rc_osc_on && !cs_fall && sclk_rise
            && edges_q == rtcs_pkg::CAL_EDGES_M1;
    endsequence

    sequence s_trim_taken;
        trim_valid_q && state_q == RTCS_WAIT && !cal_busy_q;
    endsequence

    a_source_select: assert property (@(posedge clk) disable iff (!nrst) // see R1
        ##1 (rtc_src_xtal_q == $past(clock_source_select))
            && (!$past(clock_source_select) || rtc_clk_q == $past(xtal_in_s)))
        else $error("RTC source does not follow select");

    a_rc_osc_off: assert property (@(posedge clk) disable iff (!nrst) // see R4
        (power_down || clock_source_select) |=> !rc_osc_en_q && !cal_busy_q)
        else $error("RC oscillator on while it must be off");

    a_trim_volatile: assert property (@(posedge clk) disable iff (!nrst) // see R5
        !rc_osc_on |=> !trim_valid_q && rc_trim_q == '0)
        else $error("Trim kept after RC went off");

    a_cal_start: assert property (@(posedge clk) disable iff (!nrst) // see R3
        (state_q == RTCS_CAL && $past(state_q) != RTCS_CAL)
            |-> $past(state_q) == RTCS_CMD && $past(cmd_word) == rtcs_pkg::TRIM_CMD)
        else $error("Calibration began without trim command");

    a_trim_apply: assert property (@(posedge clk) disable iff (!nrst) // see R9
        s_last_ref_edge |=> s_trim_taken)
        else $error("Trim not applied at last reference edge");

    a_trim_hold: assert property (@(posedge clk) disable iff (!nrst) // see R9
        trim_valid_q && rc_osc_on && state_q != RTCS_CAL |=> $stable(rc_trim_q))
        else $error("Trim changed while oscillator stayed on");

    a_cal_abort: assert property (@(posedge clk) disable iff (!nrst) // see R12
        // An oscillator loss in the same cycle clears the trim instead
        state_q == RTCS_CAL && cs_fall && rc_osc_on
            |=> state_q == RTCS_IDLE && $stable(rc_trim_q))
        else $error("Chip select fall did not end calibration");

    a_sdi_ignored: assert property (@(posedge clk) disable iff (!nrst) // see R12
        state_q == RTCS_CAL |=> $stable(cmd_q))
        else $error("Serial data taken during calibration");

endmodule
